// ### rtl/ecls_pkg.sv
// Constants, register map and encodings for the embedded clock lane serdes
// Contract
// - Mode bit picks two or four lanes
// - Every lane payload is twenty bits; the code carries 16 data bits per lane in a 20-bit frame
// - Two-lane mode: word split over two lanes
// - Four-lane mode: two words per half-rate frame
// - Edge select picks rising or falling capture
// - Capture only after transmit PLL locked
// - Scramble and DC-balance every lane
// - Receiver detects lane count without training
// - Receiver removes skew up to 0.4 period
// - Lock only when all lanes locked
// - Recovered clock synchronous, polarity selectable
// - One missed clock drops lock, resynchronize
// - Master lane locks first, then others
// - Transmit power-down stops PLL, tri-states lanes
// - Transmit relocks PLL before sending data
// - Receive power-down stops, restart relocks
// - Two-lane mode floats lanes three and two
// - Output enable or power-down floats outputs
// - Boost current lasts one bit only
// - One boost setting for all lanes
// - Floating transmitter forces full resynchronization
// - Receive lock within bounded recovered periods
package ecls_pkg;

  // ********************************************************************
  // Line framing
  // ********************************************************************
  localparam int         FRAME_BITS   = 20;
  localparam int         DATA_BITS    = 16;
  localparam logic [1:0] FRAME_MARK   = 2'h2;
  localparam logic [4:0] FRAME_LAST   = 5'(FRAME_BITS - 1);
  localparam logic [4:0] DC_MID       = 5'(DATA_BITS / 2);
  localparam logic [4:0] SAMPLE_OFS   = 5'(FRAME_BITS / 2);
  localparam logic [4:0] QTR_OFS      = 5'(FRAME_BITS / 4);

  // ********************************************************************
  // Rates, lock and skew figures
  // ********************************************************************
  localparam int         DUAL_MAX_MHZ = 50;
  localparam int         QUAD_MAX_MHZ = 85;
  localparam int         SKEW_TENTHS  = 4;
  localparam int         SKEW_BITS    = FRAME_BITS * SKEW_TENTHS / 10;
  localparam logic [4:0] TX_PLL_EDGES = 5'h10;
  localparam int         LOCK_FRAMES_N = 4;
  localparam logic [2:0] LOCK_FRAMES  = 3'(LOCK_FRAMES_N);
  localparam logic [7:0] DETECT_CYCLES = 8'((LOCK_FRAMES_N + 3) * FRAME_BITS);
  localparam int         LOCK_KPER_DUAL = 128;
  localparam int         LOCK_KPER_QUAD = 256;
  localparam int         LOCK_CYC_DUAL = LOCK_KPER_DUAL * 1024 * FRAME_BITS;
  localparam int         LOCK_CYC_QUAD =
    LOCK_KPER_QUAD * 1024 * (FRAME_BITS / 2);
  localparam int         LOCK_W       = 22;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [3:0] ADR_CTRL     = 4'h0;
  localparam logic [3:0] ADR_STATUS   = 4'h4;
  localparam int         CTRL_TX_PD_N = 0;
  localparam int         CTRL_QUAD    = 1;
  localparam int         CTRL_TX_EDGE = 2;
  localparam int         CTRL_RX_PD_N = 3;
  localparam int         CTRL_RX_OE   = 4;
  localparam int         CTRL_RX_EDGE = 5;
  localparam int         CTRL_PREEMPH = 6;
  localparam logic [6:0] CTRL_RESET   = 7'h00;

  typedef enum logic [1:0] {
    RX_OFF         = 2'b00,
    RX_HUNT_MASTER = 2'b01,
    RX_HUNT_REST   = 2'b10,
    RX_LOCKED      = 2'b11
  } ecls_rx_state_t;

endpackage

// ### rtl/ecls_top.sv
// Transmit and receive logic of the embedded clock lane serdes
`timescale 1ns/1ps
module ecls_top import ecls_pkg::*; #(
  parameter int LOCK_LIMIT_CYCLES = LOCK_CYC_DUAL
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_tx_parallel_clock,
  input  wire logic [31:0] i_tx_parallel_word,
  output logic      [3:0]  o_serial_lane_out,
  output logic      [3:0]  o_serial_lane_oe,
  output logic      [3:0]  o_serial_lane_boost,
  input  wire logic [3:0]  i_serial_lane_in,
  output logic      [31:0] o_rx_parallel_word,
  output logic             o_rx_parallel_word_oe,
  output logic             o_recovered_clock_out,
  output logic             o_recovered_clock_oe,
  output logic             o_rx_lock
);

  if (LOCK_LIMIT_CYCLES <= int'(DETECT_CYCLES) ||
      LOCK_LIMIT_CYCLES >= (1 << LOCK_W)) begin : g_bad_limit
    $error("LOCK_LIMIT_CYCLES out of range");
  end

  function automatic logic [4:0] ones16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < 16; k++) n = n + {4'h0, v[k]};
    return n;
  endfunction

  // ********************************************************************
  // Reset release and input synchronisers
  // ********************************************************************
  logic        rst_meta_reg;
  logic        rst_n_reg;
  logic [36:0] in_meta_reg;
  logic [36:0] in_sync_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      in_meta_reg <= 37'h0;
      in_sync_reg <= 37'h0;
    end else begin
      in_meta_reg <= {i_serial_lane_in, i_tx_parallel_clock,
                      i_tx_parallel_word};
      in_sync_reg <= in_meta_reg;
    end
  end

  logic [31:0] tx_word;
  logic        pclk;
  logic [3:0]  lane_in;
  assign tx_word = in_sync_reg[31:0];
  assign pclk    = in_sync_reg[32];
  assign lane_in = in_sync_reg[36:33];

  // ********************************************************************
  // Wishbone slave
  // ********************************************************************
  logic [6:0]  ctrl_reg;
  logic        wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic [31:0] status;
  logic        wb_req;
  logic        tx_locked_reg;
  logic        lock_out_reg;
  logic        rx_quad_reg;
  logic [3:0]  lane_lock;

  assign wb_req = i_wb_cyc & i_wb_stb & ~wb_ack_reg;
  assign status = {24'h0, lane_lock, 1'b0, rx_quad_reg, lock_out_reg,
                   tx_locked_reg};

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wb_req & i_wb_we & i_wb_sel[0] & (i_wb_adr == ADR_CTRL)) begin
      ctrl_reg <= i_wb_dat[6:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
    end else begin
      wb_ack_reg <= wb_req;
      if (wb_req & ~i_wb_we) begin
        if (i_wb_adr == ADR_CTRL) wb_dat_reg <= {25'h0, ctrl_reg};
        else if (i_wb_adr == ADR_STATUS) wb_dat_reg <= status;
        else wb_dat_reg <= 32'h0;
      end
    end
  end

  assign o_wb_ack = wb_ack_reg;
  assign o_wb_dat = wb_dat_reg;

  logic tx_pd_n;
  logic tx_quad;
  logic tx_edge;
  logic rx_pd_n;
  logic rx_oe;
  logic rx_edge;
  logic preemph;
  assign tx_pd_n = ctrl_reg[CTRL_TX_PD_N];
  assign tx_quad = ctrl_reg[CTRL_QUAD];
  assign tx_edge = ctrl_reg[CTRL_TX_EDGE];
  assign rx_pd_n = ctrl_reg[CTRL_RX_PD_N];
  assign rx_oe   = ctrl_reg[CTRL_RX_OE];
  assign rx_edge = ctrl_reg[CTRL_RX_EDGE];
  assign preemph = ctrl_reg[CTRL_PREEMPH];

  // ********************************************************************
  // Transmit PLL model and word capture
  // ********************************************************************
  logic        pclk_d_reg;
  logic [4:0]  tx_pll_cnt_reg;
  logic        tx_phase_reg;
  logic [31:0] hold_a_reg;
  logic [31:0] hold_b_reg;
  logic [4:0]  tx_bit_reg;
  logic        pclk_rise;
  logic        pclk_fall;
  logic        cap_edge;
  logic        tx_load;

  assign pclk_rise = pclk & ~pclk_d_reg;
  assign pclk_fall = ~pclk & pclk_d_reg;
  assign cap_edge  = tx_edge ? pclk_rise : pclk_fall;
  assign tx_load   = tx_locked_reg & (tx_bit_reg == 5'h00);

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pclk_d_reg     <= 1'b0;
      tx_pll_cnt_reg <= 5'h00;
      tx_locked_reg  <= 1'b0;
    end else begin
      pclk_d_reg <= pclk;
      if (!tx_pd_n) begin
        tx_pll_cnt_reg <= 5'h00;
        tx_locked_reg  <= 1'b0;
      end else if (pclk_rise & ~tx_locked_reg) begin
        tx_pll_cnt_reg <= tx_pll_cnt_reg + 5'h01;
        if (tx_pll_cnt_reg == TX_PLL_EDGES - 5'h01) tx_locked_reg <= 1'b1;
      end
    end
  end

  // Quad pairs alternate edges into two holds; the frame engine just
  // takes the latest pair, so a slow or fast parallel clock never stalls
  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_phase_reg <= 1'b0;
      hold_a_reg   <= 32'h0;
      hold_b_reg   <= 32'h0;
    end else if (!tx_locked_reg) begin
      tx_phase_reg <= 1'b0;
    end else if (cap_edge) begin
      tx_phase_reg <= tx_quad & ~tx_phase_reg;
      if (tx_phase_reg) hold_b_reg <= tx_word;
      else hold_a_reg <= tx_word;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) tx_bit_reg <= 5'h00;
    else if (!tx_locked_reg) tx_bit_reg <= 5'h00;
    else if (tx_bit_reg == FRAME_LAST) tx_bit_reg <= 5'h00;
    else tx_bit_reg <= tx_bit_reg + 5'h01;
  end

  // ********************************************************************
  // Transmit lanes
  // ********************************************************************
  logic [63:0] hold_all;
  assign hold_all = {hold_b_reg, hold_a_reg};

  for (genvar i = 0; i < 4; i++) begin : g_tx
    logic [15:0] scr_reg;
    logic [7:0]  rd_reg;
    logic [19:0] sh_reg;
    logic        out_reg;
    logic        oe_reg;
    logic        boost_reg;
    logic [15:0] s;
    logic [4:0]  ones;
    logic [4:0]  ones_sent;
    logic        rd_pos;
    logic        rd_neg;
    logic        inv;
    logic [19:0] frame;
    logic        nbit;
    logic        oe_next;

    // Self-synchronising scrambler: the receiver needs no seed or training
    assign s = hold_all[16*i +: 16] ^ scr_reg;
    assign ones = ones16(s);
    assign rd_pos = ~rd_reg[7] & (rd_reg != 8'h00);
    assign rd_neg = rd_reg[7];
    assign inv = (ones > DC_MID) ? rd_pos : (ones < DC_MID) ? rd_neg : 1'b0;
    assign ones_sent = inv ? 5'h10 - ones : ones;
    assign frame = {FRAME_MARK, inv ? ~s : s, inv, ~inv};
    assign nbit = tx_load ? frame[19] : sh_reg[18];
    assign oe_next = tx_pd_n & tx_locked_reg & ((i < 2) | tx_quad);

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        scr_reg <= 16'h0;
        rd_reg  <= 8'h00;
        sh_reg  <= 20'h0;
      end else if (tx_load) begin
        scr_reg <= s;
        rd_reg  <= rd_reg + {3'h0, ones_sent} - {3'h0, DC_MID};
        sh_reg  <= frame;
      end else begin
        sh_reg  <= {sh_reg[18:0], 1'b0};
      end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        out_reg   <= 1'b0;
        oe_reg    <= 1'b0;
        boost_reg <= 1'b0;
      end else begin
        oe_reg    <= oe_next;
        out_reg   <= oe_next & nbit;
        boost_reg <= preemph & oe_next & (nbit != out_reg);
      end
    end

    assign o_serial_lane_out[i]   = out_reg;
    assign o_serial_lane_oe[i]    = oe_reg;
    assign o_serial_lane_boost[i] = boost_reg;
  end

  // ********************************************************************
  // Receive lanes: frame hunt, lock count, descramble
  // ********************************************************************
  ecls_rx_state_t rx_state_reg;
  logic [3:0]     lane_miss;
  logic [3:0]     lane_hunt;
  logic [63:0]    pay_all;
  logic           rx_flush;
  logic           miss_any;
  logic [4:0]     ref_cnt;

  for (genvar i = 0; i < 4; i++) begin : g_rx
    logic [19:0] rsh_reg;
    logic [4:0]  cnt_reg;
    logic        aligned_reg;
    logic [2:0]  good_reg;
    logic        lock_reg;
    logic [15:0] prev_reg;
    logic [15:0] pay_reg;
    logic        valid;
    logic        fend;
    logic [15:0] s;

    assign valid = (rsh_reg[19:18] == FRAME_MARK) & (rsh_reg[1] != rsh_reg[0]);
    assign fend  = aligned_reg & (cnt_reg == FRAME_LAST);
    assign s     = rsh_reg[1] ? ~rsh_reg[17:2] : rsh_reg[17:2];
    assign lane_hunt[i] = (rx_state_reg != RX_OFF) &
      ((i == 0) | (lane_lock[0] &
       ((i < 2) | (rx_state_reg != RX_LOCKED) | rx_quad_reg)));

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) rsh_reg <= 20'h0;
      else rsh_reg <= {rsh_reg[18:0], lane_in[i]};
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        aligned_reg <= 1'b0;
        cnt_reg     <= 5'h00;
        good_reg    <= 3'h0;
        lock_reg    <= 1'b0;
        prev_reg    <= 16'h0;
        pay_reg     <= 16'h0;
      end else if (rx_flush | ~lane_hunt[i]) begin
        aligned_reg <= 1'b0;
        cnt_reg     <= 5'h00;
        good_reg    <= 3'h0;
        lock_reg    <= 1'b0;
      end else if (!aligned_reg) begin
        if (valid) aligned_reg <= 1'b1;
      end else begin
        cnt_reg <= (cnt_reg == FRAME_LAST) ? 5'h00 : cnt_reg + 5'h01;
        if (fend & valid) begin
          prev_reg <= s;
          pay_reg  <= s ^ prev_reg;
          if (good_reg != LOCK_FRAMES) good_reg <= good_reg + 3'h1;
          else lock_reg <= 1'b1;
        end else if (fend) begin
          aligned_reg <= 1'b0;
          good_reg    <= 3'h0;
          lock_reg    <= 1'b0;
        end
      end
    end

    assign lane_lock[i] = lock_reg;
    assign lane_miss[i] = fend & ~valid & lock_reg;
    assign pay_all[16*i +: 16] = pay_reg;
  end

  assign ref_cnt  = g_rx[0].cnt_reg;
  assign miss_any = |lane_miss;

  // ********************************************************************
  // Receive sequencing: master first, mode detect, watchdog
  // ********************************************************************
  logic [LOCK_W-1:0] wd_reg;
  logic [7:0]        det_reg;
  logic              wd_expire;

  assign wd_expire = (rx_state_reg != RX_LOCKED) &
                     (wd_reg == LOCK_W'(LOCK_LIMIT_CYCLES - 1));
  assign rx_flush  = (rx_state_reg == RX_OFF) | miss_any | wd_expire;

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_state_reg <= RX_OFF;
      wd_reg       <= '0;
      det_reg      <= 8'h00;
      rx_quad_reg  <= 1'b0;
    end else if (!rx_pd_n) begin
      rx_state_reg <= RX_OFF;
    end else if (miss_any | wd_expire) begin
      rx_state_reg <= RX_HUNT_MASTER;
      wd_reg       <= '0;
      det_reg      <= 8'h00;
    end else begin
      unique case (rx_state_reg)
        RX_OFF: begin
          rx_state_reg <= RX_HUNT_MASTER;
          wd_reg       <= '0;
        end
        RX_HUNT_MASTER: begin
          wd_reg  <= wd_reg + 1'b1;
          det_reg <= 8'h00;
          if (lane_lock[0]) rx_state_reg <= RX_HUNT_REST;
        end
        RX_HUNT_REST: begin
          wd_reg <= wd_reg + 1'b1;
          if (det_reg != DETECT_CYCLES) begin
            det_reg <= det_reg + 8'h01;
          end else if (lane_lock[1]) begin
            rx_quad_reg  <= &lane_lock[3:2];
            rx_state_reg <= RX_LOCKED;
          end
        end
        RX_LOCKED: begin
          wd_reg <= '0;
        end
      endcase
    end
  end

  // ********************************************************************
  // Receive output: deskewed word and recovered clock
  // ********************************************************************
  logic [31:0] word_reg;
  logic [31:0] pend_reg;
  logic        rclk_reg;
  logic        data_oe_reg;
  logic [4:0]  ref_mod;
  logic        lvl;
  logic        locked_now;

  // Sampling half a frame after lane 0 ends leaves room for SKEW_BITS
  // of skew either way; more than that would mix payloads
  assign locked_now = (rx_state_reg == RX_LOCKED) & ~miss_any;
  assign ref_mod = (ref_cnt >= SAMPLE_OFS) ? ref_cnt - SAMPLE_OFS : ref_cnt;
  assign lvl = rx_quad_reg ?
    ((ref_mod >= QTR_OFS - 5'h01) & (ref_mod < SAMPLE_OFS - 5'h01)) :
    ((ref_cnt == FRAME_LAST) | (ref_cnt < SAMPLE_OFS - 5'h01));

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      word_reg     <= 32'h0;
      pend_reg     <= 32'h0;
      rclk_reg     <= 1'b0;
      data_oe_reg  <= 1'b0;
      lock_out_reg <= 1'b0;
    end else begin
      lock_out_reg <= locked_now;
      data_oe_reg  <= rx_pd_n & rx_oe;
      rclk_reg     <= locked_now & (lvl ~^ rx_edge);
      if (!locked_now) begin
        word_reg <= 32'h0;
      end else if (ref_cnt == SAMPLE_OFS - 5'h01) begin
        word_reg <= pay_all[31:0];
        pend_reg <= pay_all[63:32];
      end else if (rx_quad_reg & (ref_cnt == FRAME_LAST)) begin
        word_reg <= pend_reg;
      end
    end
  end

  assign o_rx_parallel_word    = word_reg;
  assign o_rx_parallel_word_oe = data_oe_reg;
  assign o_recovered_clock_out = rclk_reg;
  assign o_recovered_clock_oe  = data_oe_reg;
  assign o_rx_lock             = lock_out_reg;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n_reg);

  a_tx_pd_float: assert property (!tx_pd_n |=> o_serial_lane_oe == 4'h0)
    else $error("lanes driven in power-down");
  a_dual_upper_z: assert property (!tx_quad |=> o_serial_lane_oe[3:2] == 2'h0)
    else $error("upper lanes driven in dual mode");
  a_tx_wait_pll: assert property (!tx_locked_reg |=> o_serial_lane_oe == 4'h0)
    else $error("lanes driven before pll lock");
  a_no_early_capture: assert property (!tx_locked_reg |=> $stable(hold_a_reg))
    else $error("word captured before pll lock");
  a_frame_mark: assert property (tx_load && tx_pd_n |=> o_serial_lane_out[0] ##1 !o_serial_lane_out[0])
    else $error("frame marker missing");
  a_boost_one_bit: assert property (o_serial_lane_boost[0] |-> o_serial_lane_out[0] != $past(o_serial_lane_out[0]))
    else $error("boost on repeated bit");
  a_boost_shared: assert property (o_serial_lane_boost != 4'h0 |-> $past(preemph))
    else $error("boost without setting");
  a_rx_out_float: assert property (!(rx_pd_n && rx_oe) |=> !o_rx_parallel_word_oe && !o_recovered_clock_oe)
    else $error("receive outputs driven");
  a_lock_all_lanes: assert property (o_rx_lock |->
    $past(lane_lock[0] && lane_lock[1] && (!rx_quad_reg || &lane_lock[3:2])))
    else $error("lock without lanes");
  a_word_invalid: assert property (!o_rx_lock |-> o_rx_parallel_word == 32'h0)
    else $error("word shown while unlocked");
  a_miss_unlock: assert property (miss_any |=> !o_rx_lock ##1 rx_state_reg == RX_HUNT_MASTER || !rx_pd_n)
    else $error("lock held after miss");
  a_master_first: assert property (|lane_lock[3:1] |-> lane_lock[0])
    else $error("slave lane locked before master");
  a_rx_pd_unlock: assert property (!rx_pd_n |-> ##2 !o_rx_lock)
    else $error("lock during power-down");

  c_rx_lock: cover property ($rose(o_rx_lock));
  c_quad_lock: cover property (o_rx_lock && rx_quad_reg);
  c_tx_pll: cover property ($rose(tx_locked_reg));
  c_lane_miss: cover property (miss_any);

endmodule // ecls_top

// ### verification/ecls_far_side.sv
// Far side model: parallel source and serial lane loopback
`timescale 1ns/1ps
module ecls_far_side (
  input  wire logic       i_clk_sys,
  input  wire logic       i_run,
  input  wire logic [3:0] i_cut,
  input  wire logic [3:0] i_lane_out,
  input  wire logic [3:0] i_lane_oe,
  output logic            o_pclk,
  output logic      [3:0] o_lane_in
);
  logic [3:0] last_reg = 4'h0;
  logic [3:0] drive;
  logic [3:0] en;
  logic [1:0] skew_reg = 2'h0;
  // ****************************************************************
  // Parallel clock, 200 ns, off phase with the system clock
  // ****************************************************************
  initial begin
    o_pclk = 1'b0;
    #37;
    forever begin
      #100;
      o_pclk = i_run ? ~o_pclk : 1'b0;
    end
  end
  // ****************************************************************
  // Released or cut lane holds the inverse of its last driven bit
  // ****************************************************************
  assign en    = i_lane_oe & ~i_cut;
  assign drive = (en & i_lane_out) | (~en & ~last_reg);
  always_ff @(posedge i_clk_sys) begin
    last_reg <= (en & i_lane_out) | (~en & last_reg);
    skew_reg <= {skew_reg[0], drive[1]};
  end
  // Lane 1 arrives two bits late, well inside the skew budget
  assign o_lane_in = {drive[3:2], skew_reg[1], drive[0]};
endmodule // ecls_far_side

// ### verification/embedded_clock_lane_serdes_tb.sv
// Self-checking bench for the embedded clock lane serdes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module embedded_clock_lane_serdes_tb;
  import ecls_pkg::*;
  logic        clk, rst_n, cyc, stb, we, ack, run, pclk, lock;
  logic        word_oe, rclk, rclk_oe;
  logic [3:0]  adr, sel, cut, lane_out, lane_oe, boost, lane_in, prev;
  logic [31:0] dat, rdat, rq, word, rword;
  logic [31:0] sent[$];
  int          ctrl_m, n_tests, n_mismatch;
  int          seed = 32'h4256ea06;

  ecls_far_side far (.i_clk_sys(clk), .i_run(run),
    .i_cut(cut), .i_lane_out(lane_out), .i_lane_oe(lane_oe),
    .o_pclk(pclk), .o_lane_in(lane_in));
  ecls_top #(.LOCK_LIMIT_CYCLES(2000)) uut (.i_clk_sys(clk),
    .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_tx_parallel_clock(pclk), .i_tx_parallel_word(word),
    .o_serial_lane_out(lane_out), .o_serial_lane_oe(lane_oe),
    .o_serial_lane_boost(boost), .i_serial_lane_in(lane_in),
    .o_rx_parallel_word(rword), .o_rx_parallel_word_oe(word_oe),
    .o_recovered_clock_out(rclk), .o_recovered_clock_oe(rclk_oe),
    .o_rx_lock(lock));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************************************
  // Bus, wait and closing tasks
  // ****************************************************************
  task automatic wb(input logic w, input logic [3:0] a, input int d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rq = rdat;
    {cyc, stb, we} <= 3'b000;
    if (w && a == ADR_CTRL) ctrl_m = d & 32'h7F;
    `CHK("ack", 1'b1, ack)
  endtask
  task automatic rd(input logic [3:0] a, input int m, input int e);
    wb(1'b0, a, 0);
    `CHK("read", e, rq & m)
  endtask
  task automatic wait_lock(input logic lv, input int lim);
    int n;
    n = 0;
    while (lock !== lv && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK("lock", lv, lock)
  endtask
  task automatic go(input int c, input logic [3:0] eoe);
    int   n;
    logic p;
    n = 0;
    word <= $random(seed);
    @(posedge clk);
    sent.push_back(word);
    wb(1'b1, ADR_CTRL, c);
    wait_lock(1'b1, 4000);
    repeat (60) @(posedge clk);
    `CHK("word", sent[$], rword)
    `CHK("lane_oe", eoe, lane_oe)
    for (int i = 0; i < 40; i++) begin
      p = rclk;
      @(posedge clk);
      n += (rclk != p);
    end
    `CHK("rclk_edges", 4 << eoe[3], n)
    rd(ADR_STATUS, -1, {24'h0, eoe, 1'b0, eoe[3], 2'b11});
  endtask
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(25 * 60000);
    n_mismatch++;
    end_sim;
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_n, cyc, stb, we, adr, dat, sel, run, word, cut} = '0;
    ctrl_m = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("lane_oe", 4'h0, lane_oe)
    rd(ADR_CTRL, 32'h7F, ctrl_m);
    rd(4'h8, -1, 0);
    wb(1'b1, 4'h8, 32'h7D);
    rd(ADR_CTRL, 32'h7F, ctrl_m);
    run <= 1'b1;
    go(32'h7D, 4'h3);
    prev = lane_out;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      `CHK("boost", (lane_out ^ prev) & lane_oe, boost)
      prev = lane_out;
    end
    cut <= 4'h2;
    wait_lock(1'b0, 40);
    @(posedge clk);
    `CHK("word", 32'h0, rword)
    repeat (300) @(posedge clk);
    rd(ADR_STATUS, 32'h32, 32'h10);
    cut <= 4'h0;
    wait_lock(1'b1, 4000);
    wb(1'b1, ADR_CTRL, 32'h6D);
    repeat (3) @(posedge clk);
    `CHK("oe", 3'b001, {word_oe, rclk_oe, lock})
    wb(1'b1, ADR_CTRL, 32'h75);
    wait_lock(1'b0, 5);
    `CHK("word_oe", 1'b0, word_oe)
    wb(1'b1, ADR_CTRL, 32'h7D);
    wait_lock(1'b1, 4000);
    wb(1'b1, ADR_CTRL, 32'h7C);
    repeat (3) @(posedge clk);
    `CHK("lane_oe", 4'h0, lane_oe)
    wait_lock(1'b0, 25);
    go(32'h3B, 4'hF);
    `CHK("boost", 4'h0, boost)
    rd(ADR_CTRL, 32'h7F, ctrl_m);
    end_sim;
  end
endmodule // embedded_clock_lane_serdes_tb
